// ### hw/sync_burst_sram_dcd_port.sv
/*
 * Device side of a synchronous burst SRAM with dual cycle deselect:
 * command decode, 2-bit burst counter, flow-through or pipelined reads,
 * byte and global writes, sleep and asynchronous output enable.
 * Assumes the controller drives every synchronous input from logic on clk;
 * mode pins, sleep and output enable come from outside; mode pins are synchronised, sleep too except at the output gate, output enable is not.
 */
`timescale 1ns/1ps

module sync_burst_sram_dcd_port #(
  parameter bit WIDE_ORG = 1'b0,
  parameter int DATA_BITS = WIDE_ORG ? sram_port_pkg::X36_DATA_BITS
                                     : sram_port_pkg::X18_DATA_BITS,
  parameter int ADDR_BITS = WIDE_ORG ? sram_port_pkg::X36_ADDR_BITS
                                     : sram_port_pkg::X18_ADDR_BITS,
  parameter int LANES = DATA_BITS / sram_port_pkg::LANE_BITS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_BITS-1:0] address,
  input wire logic chip_select_n,
  input wire logic processor_addr_strobe_n,
  input wire logic controller_addr_strobe_n,
  input wire logic burst_advance_n,
  input wire logic [LANES-1:0] lane_write_enable_n,
  input wire logic partial_write_enable_n,
  input wire logic all_bytes_write_n,
  input wire logic [DATA_BITS-1:0] dqIn,
  output logic [DATA_BITS-1:0] dqOut,
  output logic dqOutEnable_n,
  input wire logic outputEnable_n,
  input wire logic sleep_request,
  input wire logic flowthrough_select_n,
  input wire logic flowthroughPinDriven,
  input wire logic linear_order_select_n,
  input wire logic orderPinDriven,
  output logic powerDown,
  output logic two_cycle_deselect
);

  localparam int BB = sram_port_pkg::BURST_BITS;
  localparam int SS = sram_port_pkg::SYNC_STAGES;

  ////////////////////////////////////////////////////////////////////////
  // Burst address for one beat: linear adds, interleaved XORs
  function automatic logic [BB-1:0] burstLow(
    input logic [BB-1:0] start,
    input logic [BB-1:0] beat,
    input logic linearOrder
  );
    logic [BB-1:0] sum;
    sum = start + beat;
    if (linearOrder)
      return sum;
    else
      return start ^ beat;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers for the pins that come from outside the clock domain
  logic [SS-1:0] sleepSync;
  logic [SS-1:0] flowSync;
  logic [SS-1:0] flowDrivenSync;
  logic [SS-1:0] orderSync;
  logic [SS-1:0] orderDrivenSync;

  // Two flip-flops per pin; only the last stage is read
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sleepSync <= '0;
      flowSync <= '0;
      flowDrivenSync <= '0;
      orderSync <= '0;
      orderDrivenSync <= '0;
    end
    else
    begin
      sleepSync <= {sleepSync[SS-2:0], sleep_request};
      flowSync <= {flowSync[SS-2:0], flowthrough_select_n};
      flowDrivenSync <= {flowDrivenSync[SS-2:0], flowthroughPinDriven};
      orderSync <= {orderSync[SS-2:0], linear_order_select_n};
      orderDrivenSync <= {orderDrivenSync[SS-2:0], orderPinDriven};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode pins: an undriven pin takes its pull level
  logic flowPinLevel;
  logic orderPinLevel;
  logic pipelineMode;
  logic linearOrder;
  logic asleep;

  assign flowPinLevel = flowDrivenSync[SS-1] ? flowSync[SS-1]
                                             : sram_port_pkg::FLOWTHROUGH_PULL_LEVEL;
  assign orderPinLevel = orderDrivenSync[SS-1] ? orderSync[SS-1]
                                               : sram_port_pkg::ORDER_PULL_LEVEL;
  assign pipelineMode = flowPinLevel;
  assign linearOrder = ~orderPinLevel;
  assign asleep = sleepSync[SS-1];

  ////////////////////////////////////////////////////////////////////////
  // Command decode of the sampled synchronous inputs
  typedef enum {
    CMD_IDLE,
    CMD_DESELECT,
    CMD_START_READ,
    CMD_START_WRITE,
    CMD_BURST_READ,
    CMD_BURST_WRITE
  } command_e;

  command_e command;
  logic selected;
  logic anyWrite;
  logic strobeTaken;
  logic [LANES-1:0] writeLanes;

  // Global write wins; otherwise partial write picks the low lane enables
  always_comb
  begin
    writeLanes = '0;
    if (!all_bytes_write_n)
      writeLanes = '1;
    else if (!partial_write_enable_n)
      writeLanes = ~lane_write_enable_n;
  end

  assign anyWrite = |writeLanes;

  // Processor strobe is ignored while the chip is not selected
  always_comb
  begin
    command = CMD_IDLE;
    strobeTaken = 1'b0;
    if (asleep)
      command = CMD_IDLE;
    else if (!processor_addr_strobe_n && !chip_select_n)
    begin
      command = CMD_START_READ;
      strobeTaken = 1'b1;
    end
    else if (!controller_addr_strobe_n)
    begin
      strobeTaken = 1'b1;
      if (chip_select_n)
        command = CMD_DESELECT;
      else if (anyWrite)
        command = CMD_START_WRITE;
      else
        command = CMD_START_READ;
    end
    else if (selected)
    begin
      if (anyWrite)
        command = CMD_BURST_WRITE;
      else
        command = CMD_BURST_READ;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Burst address register and counter
  logic [ADDR_BITS-1:0] burstBase;
  logic [BB-1:0] burstStart;
  logic [BB-1:0] beat;

  // A start strobe loads the external address; advance steps the beat
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      burstBase <= '0;
      burstStart <= sram_port_pkg::BEAT_ZERO;
      beat <= sram_port_pkg::BEAT_ZERO;
    end
    else if (strobeTaken && command != CMD_DESELECT && command != CMD_IDLE)
    begin
      burstBase <= address;
      burstStart <= address[BB-1:0];
      beat <= sram_port_pkg::BEAT_STEP; // next beat after the loaded one
    end
    else if (selected && !burst_advance_n && !asleep)
    begin
      beat <= beat + sram_port_pkg::BEAT_STEP;
    end
  end

  // Selection follows the last strobe; deselect or sleep ends it
  always_ff @(posedge clk)
  begin
    if (rst)
      selected <= 1'b0;
    else if (asleep || command == CMD_DESELECT)
      selected <= 1'b0;
    else if (command == CMD_START_READ || command == CMD_START_WRITE)
      selected <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Array address for this edge: fresh on a strobe, counted in a burst
  logic [ADDR_BITS-1:0] accessAddr;
  logic doWrite;
  logic doRead;

  always_comb
  begin
    accessAddr = burstBase;
    case (command)
      CMD_START_READ, CMD_START_WRITE:
        accessAddr = address;
      CMD_BURST_READ, CMD_BURST_WRITE:
      begin
        accessAddr = burstBase;
        if (!burst_advance_n)
          accessAddr[BB-1:0] = burstLow(burstStart, beat, linearOrder);
        else
          accessAddr[BB-1:0] = burstLow(burstStart, beat - sram_port_pkg::BEAT_STEP,
                                        linearOrder);
      end
      default:
        accessAddr = burstBase;
    endcase
  end

  assign doWrite = (command == CMD_START_WRITE) || (command == CMD_BURST_WRITE);
  assign doRead = (command == CMD_START_READ) || (command == CMD_BURST_READ);

  ////////////////////////////////////////////////////////////////////////
  // Storage; write finishes inside the sampling edge
  logic [DATA_BITS-1:0] readData;

  sram_cell_array #(
    .DATA_BITS(DATA_BITS),
    .ADDR_BITS(ADDR_BITS),
    .LANES(LANES)
  ) cellArray (
    .clk(clk),
    .writeStrobe(doWrite),
    .writeLanes(writeLanes),
    .writeAddr(accessAddr),
    .writeData(dqIn),
    .readAddr(accessAddr),
    .readData(readData)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read data path: first stage is the flow-through copy
  logic [DATA_BITS-1:0] flowData;
  logic [DATA_BITS-1:0] pipeData;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      flowData <= '0;
      pipeData <= '0;
    end
    else
    begin
      if (doRead)
        flowData <= readData;
      pipeData <= flowData;
    end
  end

  // Output data register picks the stage for the current mode
  always_ff @(posedge clk)
  begin
    if (rst)
      dqOut <= '0;
    else if (pipelineMode)
      dqOut <= flowData;
    else if (doRead)
      dqOut <= readData;
  end

  ////////////////////////////////////////////////////////////////////////
  // Drive pipeline: reads and deselects move through equal stages
  logic driveStage1;
  logic driveStage2;
  logic driveStage3;
  logic driveNow;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      driveStage1 <= 1'b0;
      driveStage2 <= 1'b0;
      driveStage3 <= 1'b0;
    end
    else
    begin
      if (doRead)
        driveStage1 <= 1'b1;
      else if (command == CMD_DESELECT || doWrite || asleep || !selected)
        driveStage1 <= 1'b0;
      driveStage2 <= driveStage1;
      driveStage3 <= driveStage2;
    end
  end

  // Deselect stays pending one cycle before the outputs release, unless a write follows in flow-through mode
  assign driveNow = pipelineMode ? (driveStage1 || driveStage2)
                                 : (driveStage1 || (driveStage2 && !doWrite));

  logic driveReg;

  // Registered internal enable, gated below by the asynchronous pins
  always_ff @(posedge clk)
  begin
    if (rst)
      driveReg <= 1'b0;
    else
      driveReg <= driveNow && !asleep;
  end

  // Output enable and sleep reach the pins without a clock edge
  assign dqOutEnable_n = ~driveReg | outputEnable_n | sleep_request;

  ////////////////////////////////////////////////////////////////////////
  // Power-down status and deselect flavour
  always_ff @(posedge clk)
  begin
    if (rst)
      powerDown <= 1'b0;
    else
      powerDown <= asleep;
  end

  // This port reports dual cycle deselect from the first edge after reset
  always_ff @(posedge clk)
  begin
    if (rst)
      two_cycle_deselect <= 1'b0;
    else
      two_cycle_deselect <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Organisation check at build time
  if (LANES * sram_port_pkg::LANE_BITS != DATA_BITS)
  begin : gBadWidth
    localparam int BAD_ORGANISATION = 1 / 0;
  end

endmodule

// ### hw/sram_port_pkg.sv
/*
 * Shared constants for the synchronous burst SRAM port: organisation,
 * lane layout, burst counter width and mode pin defaults.
 * Assumes every file that needs a constant names it as sram_port_pkg::name.
 */
package sram_port_pkg;

  // Each byte lane carries eight data bits plus one parity bit
  localparam int LANE_BITS = 9;

  // Narrow organisation: 16M words of 18 bits
  localparam int X18_DATA_BITS = 18;
  localparam int X18_ADDR_BITS = 24;

  // Wide organisation: 8M words of 36 bits
  localparam int X36_DATA_BITS = 36;
  localparam int X36_ADDR_BITS = 23;

  // Burst counter width and beat count
  localparam int BURST_BITS = 2;
  localparam logic [1:0] BEAT_ZERO = 2'h0;
  localparam logic [1:0] BEAT_STEP = 2'h1;

  // Levels that the internal pull resistors give a floating mode pin
  localparam logic FLOWTHROUGH_PULL_LEVEL = 1'b1;
  localparam logic ORDER_PULL_LEVEL = 1'b1;

  // Depth of every pin synchroniser
  localparam int SYNC_STAGES = 2;

endpackage

// ### hw/sram_cell_array.sv
/*
 * Storage array of the SRAM: one write port with per-lane enables and one
 * combinational read port.
 * Assumes the caller presents write address, data and lane mask on the
 * same clock edge; the write completes within that edge.
 */
`timescale 1ns/1ps

module sram_cell_array #(
  parameter int DATA_BITS = 18,
  parameter int ADDR_BITS = 24,
  parameter int LANES = 2
) (
  input wire logic clk,
  input wire logic writeStrobe,
  input wire logic [LANES-1:0] writeLanes,
  input wire logic [ADDR_BITS-1:0] writeAddr,
  input wire logic [DATA_BITS-1:0] writeData,
  input wire logic [ADDR_BITS-1:0] readAddr,
  output logic [DATA_BITS-1:0] readData
);

  localparam int LANE_BITS = sram_port_pkg::LANE_BITS;

  logic [DATA_BITS-1:0] cells [0:(1 << ADDR_BITS)-1];

  ////////////////////////////////////////////////////////////////////////
  // Self-timed write: only the enabled lanes change
  always_ff @(posedge clk)
  begin
    if (writeStrobe)
    begin
      for (int lane = 0; lane < LANES; lane++)
      begin
        if (writeLanes[lane])
        begin
          cells[writeAddr][lane*LANE_BITS +: LANE_BITS] <=
            writeData[lane*LANE_BITS +: LANE_BITS];
        end
      end
    end
  end

  // Read port follows its address with no clock
  assign readData = cells[readAddr];

endmodule

// ### test/sram_port_checker_assertions.sv
/*
 * Checker for the burst SRAM port: output gating, sleep, deselect pipeline.
 * Assumes it is bound to the port and sees only the port's pins.
 */
`timescale 1ns/1ps

module sram_port_checker #(
  parameter int DATA_BITS = 18
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic chip_select_n,
  input wire logic processor_addr_strobe_n,
  input wire logic controller_addr_strobe_n,
  input wire logic [DATA_BITS-1:0] dqOut,
  input wire logic dqOutEnable_n,
  input wire logic outputEnable_n,
  input wire logic sleep_request,
  input wire logic powerDown,
  input wire logic two_cycle_deselect
);
  logic readCmd;
  logic deselCmd;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////
  // Commands taken while awake; sleep ignores them
  assign readCmd = !chip_select_n && !processor_addr_strobe_n && !powerDown;
  assign deselCmd = chip_select_n && !controller_addr_strobe_n && !powerDown;

  ////////////////////////////////////////
  // Gating and sleep
  property p_oe_gate;
    outputEnable_n |-> dqOutEnable_n;
  endproperty
  a_oe_gate: assert property (p_oe_gate)
    else $error("outputs driven while output enable is off");
  property p_sleep_gate;
    sleep_request |-> dqOutEnable_n;
  endproperty
  a_sleep_gate: assert property (p_sleep_gate)
    else $error("outputs driven during sleep");
  property p_sleep_on;
    sleep_request [*4] |-> powerDown;
  endproperty
  a_sleep_on: assert property (p_sleep_on)
    else $error("no power down after sleep");
  property p_sleep_off;
    !sleep_request [*4] |-> !powerDown;
  endproperty
  a_sleep_off: assert property (p_sleep_off)
    else $error("power down without sleep");

  ////////////////////////////////////////
  // Deselect pipeline and read data cause
  property p_desel_off;
    deselCmd ##1 deselCmd |-> ##2 dqOutEnable_n;
  endproperty
  a_desel_off: assert property (p_desel_off)
    else $error("outputs still on after deselect");
  property p_desel_hold;
    readCmd ##1 deselCmd |-> ##1 (outputEnable_n || sleep_request || !dqOutEnable_n) [*2];
  endproperty
  a_desel_hold: assert property (p_desel_hold)
    else $error("outputs off too early after deselect");
  property p_dq_cause;
    $changed(dqOut) |-> !$past(chip_select_n) || !$past(chip_select_n, 2);
  endproperty
  a_dq_cause: assert property (p_dq_cause)
    else $error("read data changed without a selected cycle");
  property p_dual_mode;
    !$past(rst) |-> two_cycle_deselect;
  endproperty
  a_dual_mode: assert property (p_dual_mode)
    else $error("dual cycle deselect flag low");

  c_read_desel: cover property (readCmd ##1 deselCmd);
  c_two_desel: cover property (deselCmd ##1 deselCmd);
  c_sleep: cover property (sleep_request [*4]);
  c_data: cover property ($changed(dqOut));
endmodule

bind sync_burst_sram_dcd_port sram_port_checker #(.DATA_BITS(DATA_BITS)) chk (
  .clk(clk), .rst(rst), .chip_select_n(chip_select_n),
  .processor_addr_strobe_n(processor_addr_strobe_n),
  .controller_addr_strobe_n(controller_addr_strobe_n), .dqOut(dqOut),
  .dqOutEnable_n(dqOutEnable_n), .outputEnable_n(outputEnable_n),
  .sleep_request(sleep_request), .powerDown(powerDown),
  .two_cycle_deselect(two_cycle_deselect)
);

// ### test/cache_master_model.sv
/*
 * Controller model driving the synchronous side of the SRAM port.
 * Assumes one issue call per cycle; it drives just after the falling edge.
 */
`timescale 1ns/1ps

module cache_master_model (
  input wire logic clk,
  output logic [7:0] address,
  output logic chip_select_n,
  output logic processor_addr_strobe_n,
  output logic controller_addr_strobe_n,
  output logic burst_advance_n,
  output logic [1:0] lane_write_enable_n,
  output logic partial_write_enable_n,
  output logic all_bytes_write_n,
  output logic [17:0] dqIn
);
  ////////////////////////////////////////
  // Idle, deselected bus at time zero
  initial
  begin
    {chip_select_n, processor_addr_strobe_n, controller_addr_strobe_n} = 3'h7;
    {burst_advance_n, all_bytes_write_n, partial_write_enable_n} = 3'h7;
    lane_write_enable_n = 2'h3;
    address = 8'h00;
    dqIn = 18'h0_0000;
  end

  // One command a cycle; released data toggles so no stale value passes
  task automatic issue(input logic [7:0] ctl, input logic [7:0] a, input logic [17:0] d);
    @(negedge clk);
    {chip_select_n, processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n,
      all_bytes_write_n, partial_write_enable_n, lane_write_enable_n} = ctl;
    address = a;
    dqIn = (ctl[3] && ctl[2]) ? ~dqIn : d;
  endtask
endmodule

// ### test/sync_burst_sram_dcd_port_tb.sv
/*
 * Self-checking bench for the burst SRAM port: writes, reads, bursts, modes, sleep.
 * Assumes the controller model and the bound checker from test/.
 */
`timescale 1ns/1ps

module sync_burst_sram_dcd_port_tb;
  localparam logic [7:0] DES = 8'hdf;
  localparam logic [7:0] RDC = 8'h5f;
  localparam logic [7:0] RDP = 8'h37;
  localparam logic [7:0] STEP = 8'h6f;
  localparam logic [7:0] HOLD = 8'h7f;
  localparam logic [7:0] BWR = 8'h67;
  localparam logic [15:0] MODES = 16'heb0a;
  localparam logic [11:0] BEATS = 12'h16c;
  logic clk, rst, outputEnable_n, sleep_request, flowthrough_select_n;
  logic flowthroughPinDriven, linear_order_select_n, orderPinDriven;
  logic chip_select_n, processor_addr_strobe_n, controller_addr_strobe_n;
  logic burst_advance_n, partial_write_enable_n, all_bytes_write_n;
  logic dqOutEnable_n, powerDown, two_cycle_deselect;
  logic [1:0] lane_write_enable_n;
  logic [7:0] address;
  logic [17:0] dqIn, dqOut;
  logic [17:0] refMem [0:255];
  int mismatches = 0;
  int num_checks = 0;
  bit flow = 1'b0;
  bit linear = 1'b1;

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  cache_master_model m (.clk(clk), .address(address), .chip_select_n(chip_select_n),
    .processor_addr_strobe_n(processor_addr_strobe_n),
    .controller_addr_strobe_n(controller_addr_strobe_n), .burst_advance_n(burst_advance_n),
    .lane_write_enable_n(lane_write_enable_n), .partial_write_enable_n(partial_write_enable_n),
    .all_bytes_write_n(all_bytes_write_n), .dqIn(dqIn));

  sync_burst_sram_dcd_port #(.WIDE_ORG(1'b0), .ADDR_BITS(8)) dut (.clk(clk), .rst(rst),
    .address(address), .chip_select_n(chip_select_n),
    .processor_addr_strobe_n(processor_addr_strobe_n),
    .controller_addr_strobe_n(controller_addr_strobe_n), .burst_advance_n(burst_advance_n),
    .lane_write_enable_n(lane_write_enable_n), .partial_write_enable_n(partial_write_enable_n),
    .all_bytes_write_n(all_bytes_write_n), .dqIn(dqIn), .dqOut(dqOut),
    .dqOutEnable_n(dqOutEnable_n), .outputEnable_n(outputEnable_n),
    .sleep_request(sleep_request), .flowthrough_select_n(flowthrough_select_n),
    .flowthroughPinDriven(flowthroughPinDriven), .linear_order_select_n(linear_order_select_n),
    .orderPinDriven(orderPinDriven), .powerDown(powerDown),
    .two_cycle_deselect(two_cycle_deselect));

  ////////////////////////////////////////
  // Comparison, expectation helpers and the closing task
  task automatic check(input logic [17:0] got, input logic [17:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Lanes written: every lane on global write, else enabled lanes on partial write
  function automatic logic [17:0] merged(input logic [17:0] old, input logic [17:0] d,
      input logic [3:0] w);
    logic [17:0] keep;
    keep = 18'h0_0000;
    for (int i = 0; i < 2; i++)
      if (!w[3] || (!w[2] && !w[i]))
        keep[9*i +: 9] = 9'h1ff;
    return (old & ~keep) | (d & keep);
  endfunction

  // Burst address: linear adds the beat, interleaved XORs it
  function automatic logic [7:0] beatAddr(input logic [7:0] s, input logic [1:0] b);
    return {s[7:2], linear ? s[1:0] + b : s[1:0] ^ b};
  endfunction

  // Read then deselect; check data, then hold and turn-off of the outputs
  task automatic readChk(input logic [7:0] a, input logic [7:0] ctl);
    m.issue(ctl, a, 18'h3_ffff);
    m.issue(DES, a, '0);
    if (flow)
      check(dqOut, refMem[a], "flow data");
    m.issue(DES, a, '0);
    check(dqOut, refMem[a], "read data");
    check(dqOutEnable_n, 1'b0, "drive on");
    m.issue(DES, a, '0);
    check(dqOutEnable_n, 1'b0, "deselect hold");
    m.issue(DES, a, '0);
    check(dqOutEnable_n, 1'b1, "deselect off");
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    #(50 * 5000);
    mismatches++;
    tally_and_finish;
  end

  ////////////////////////////////////////
  // Main sequence
  initial
  begin
    logic [17:0] d;
    logic [7:0] a;
    logic [7:0] s;
    logic [3:0] w;
    rst = 1'b1;
    {outputEnable_n, sleep_request, flowthrough_select_n, flowthroughPinDriven} = 4'h3;
    {linear_order_select_n, orderPinDriven} = 2'h1;
    d = 18'($urandom(20));
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (3) m.issue(DES, 8'h00, '0);
    check(two_cycle_deselect, 1'b1, "dual deselect flag");
    for (int i = 0; i < 256; i++)
    begin
      d = 18'($urandom);
      m.issue(8'h57, i[7:0], d);
      refMem[i] = d;
    end
    for (int i = 0; i < 40; i++)
    begin
      a = 8'($urandom);
      d = 18'($urandom);
      w = (i == 0) ? 4'h6 : (i == 1) ? 4'hb : 4'($urandom);
      m.issue({4'h5, w}, a, d);
      refMem[a] = merged(refMem[a], d, w);
      readChk(a, RDC);
    end
    for (int k = 0; k < 4; k++)
    begin
      w = MODES[15-4*k -: 4];
      {flowthroughPinDriven, flowthrough_select_n, orderPinDriven, linear_order_select_n} = w;
      flow = w[3] && !w[2];
      linear = w[1] && !w[0];
      repeat (4) m.issue(DES, 8'h00, '0);
      s = 8'($urandom);
      for (int b = 0; b < 4; b++)
      begin
        d = 18'($urandom);
        m.issue(b == 0 ? 8'h57 : BWR, s, d);
        refMem[beatAddr(s, b[1:0])] = d;
      end
      for (int b = 0; b < 4; b++)
        readChk(beatAddr(s, b[1:0]), RDC);
      for (int j = 0; j < 8; j++)
      begin
        m.issue(j == 0 ? RDC : j == 2 ? HOLD : j < 6 ? STEP : DES, s, '0);
        if (j >= 2 - flow && j - 2 + flow < 6)
          check(dqOut, refMem[beatAddr(s, BEATS[11-2*(j-2+flow) -: 2])], "burst");
      end
    end
    for (int i = 0; i < 4; i++)
      readChk(8'($urandom), RDP);
    a = 8'($urandom);
    readChk(a, RDC);
    m.issue(RDC, a, '0);
    repeat (2) m.issue(DES, 8'h00, '0);
    check(dqOutEnable_n, 1'b0, "drive before gate");
    outputEnable_n = 1'b1;
    #1 check(dqOutEnable_n, 1'b1, "output enable gate");
    m.issue(DES, 8'h00, '0);
    outputEnable_n = 1'b0;
    #1 check(dqOutEnable_n, 1'b0, "output enable back");
    sleep_request = 1'b1;
    #1 check(dqOutEnable_n, 1'b1, "sleep gate");
    m.issue(DES, 8'h00, '0);
    check(powerDown, 1'b0, "power down early");
    repeat (3) m.issue(DES, 8'h00, '0);
    check(powerDown, 1'b1, "power down");
    m.issue(8'h57, a, ~refMem[a]);
    sleep_request = 1'b0;
    repeat (5) m.issue(DES, 8'h00, '0);
    check(powerDown, 1'b0, "wake");
    readChk(a, RDC);
    tally_and_finish;
  end
endmodule
